// >>> rtl/flash_prot_pkg.sv
// Package for the flash erase and protection controller.
// Assumes a byte-addressed flash of 96 KB behind a single system clock.
package flash_prot_pkg;
  localparam int unsigned FLASH_BYTES    = 98304;   // 96 KB total
  localparam int unsigned UNIT_BYTES     = 1024;    // Erase unit size
  localparam int unsigned REGION_BYTES   = 2048;    // Protection region size
  localparam int unsigned ADDR_W         = 17;
  localparam int unsigned WORD_W         = 32;
  localparam int unsigned WORDS_PER_UNIT = UNIT_BYTES / 4;
  localparam int unsigned NUM_UNITS      = FLASH_BYTES / UNIT_BYTES;
  localparam int unsigned NUM_REGIONS    = FLASH_BYTES / REGION_BYTES;
  localparam int unsigned UNIT_LSB       = 10;      // Address bit of erase unit
  localparam int unsigned REGION_LSB     = 11;      // Address bit of region
  localparam int unsigned WORD_LSB       = 2;
  localparam int unsigned WIDX_W         = 8;       // Word index within a unit
  localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffff_ffff;

  // Origin of a request
  typedef enum logic [1:0] {
    SRC_FETCH,
    SRC_DATA,
    SRC_DEBUG
  } req_src_type;

  // Operation requested
  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ERASE
  } req_op_type;
endpackage

// >>> rtl/flash_array_if.sv
// Interface carrying array accesses from the controller to the storage model.
// Assumes one access per cycle, read data registered in the array.
`timescale 1ns/100ps
interface flash_array_if;
  import flash_prot_pkg::*;
  logic                      we;
  logic [flash_prot_pkg::ADDR_W-WORD_LSB-1:0] waddr;
  logic [WORD_W-1:0]         wdata;
  logic                      re;
  logic [flash_prot_pkg::ADDR_W-WORD_LSB-1:0] raddr;
  logic [WORD_W-1:0]         rdata;
  modport ctrl  (output we, waddr, wdata, re, raddr, input rdata);
  modport array (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// >>> rtl/flash_store.sv
// ****************************************
// Flash word storage
// ****************************************
// Holds the whole flash array as words; read data come out of a register.
// Assumes the controller never writes and reads the same word in one cycle.
`timescale 1ns/100ps
module flash_store #(
  parameter int unsigned DEPTH = 24576
) (
  input  wire logic  clk_sys_i,
  flash_array_if.array bus
);
  import flash_prot_pkg::*;

  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] rdata_reg;

  // Plain synchronous RAM, no reset so it maps onto block memory
  always_ff @(posedge clk_sys_i) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
    if (bus.re) begin
      rdata_reg <= mem[bus.raddr];
    end
  end

  assign bus.rdata = rdata_reg;
endmodule // flash_store

// >>> rtl/flash_erase_protect_ctrl.sv
// ****************************************
// Flash erase and protection controller
// ****************************************
// Decodes fetch, data and debug requests to the flash, runs unit erases and
// enforces per-region read-only and execute-only protection.
// Assumes the requester holds req until ack and keeps inputs stable meanwhile.
// Protection bits come from set pulses and stay until reset.
// Operation
// - Flash holds 96 KB and every address within it is decoded.
// - Erase works on one 1 KB unit, leaving all other units alone.
// - A finished erase leaves every bit of the unit at one.
// - Protection applies per 2 KB region, each read-only or execute-only.
// - Read-only regions refuse erase and program but still serve reads.
// - Execute-only regions refuse erase, program, and non-fetch reads.
`timescale 1ns/100ps
module flash_erase_protect_ctrl #(
  parameter int unsigned REGIONS = flash_prot_pkg::NUM_REGIONS
) (
  input  wire logic                              clk_sys_i,
  input  wire logic                              arst_n_i,
  input  wire logic                              req_i,
  input  wire flash_prot_pkg::req_op_type        op_i,
  input  wire flash_prot_pkg::req_src_type       src_i,
  input  wire logic [flash_prot_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [flash_prot_pkg::WORD_W-1:0] wdata_i,
  input  wire logic [REGIONS-1:0]                ro_set_i,
  input  wire logic [REGIONS-1:0]                xo_set_i,
  input  wire logic                              viol_clr_i,
  output logic                                   ack_o,
  output logic                                   busy_o,
  output logic [flash_prot_pkg::WORD_W-1:0]      rdata_o,
  output logic                                   denied_o,
  output logic                                   viol_o,
  output logic [REGIONS-1:0]                     ro_o,
  output logic [REGIONS-1:0]                     xo_o
);
  import flash_prot_pkg::*;

  // Sequencer states: waiting, one read in flight, or a unit erase running
  typedef enum {ST_IDLE, ST_READ, ST_ERASE} state_type;

  // Word address width and region index width, both derived from the byte map
  localparam int unsigned WADDR_W = ADDR_W - WORD_LSB;
  localparam int unsigned REG_W   = ADDR_W - REGION_LSB;

  // Array port: one write or one read per cycle, read data one cycle late.
  // Keeping the storage behind an interface lets a real macro replace it later.
  flash_array_if arr ();

  // Word-wide storage for the whole flash map
  flash_store #(
    .DEPTH (FLASH_BYTES >> WORD_LSB)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .bus       (arr)
  );

  // ****************************************
  // Request decode
  // ****************************************
  // Decode results for the request currently on the inputs
  logic             in_range;
  logic [REG_W-1:0] region;
  logic             reg_ro;
  logic             reg_xo;
  logic             refuse;

  // Anything beyond 96 KB is refused rather than aliased onto low memory
  always_comb begin
    in_range = (32'(addr_i) < FLASH_BYTES);
    region   = addr_i[ADDR_W-1:REGION_LSB];
    reg_ro   = in_range ? ro_o[region] : 1'b0;
    reg_xo   = in_range ? xo_o[region] : 1'b0;
    refuse   = !in_range;
    if ((op_i != OP_READ) && (reg_ro || reg_xo)) begin
      refuse = 1'b1;
    end
    if ((op_i == OP_READ) && reg_xo && (src_i != SRC_FETCH)) begin
      refuse = 1'b1;
    end
  end

  // ****************************************
  // Protection bits
  // ****************************************
  // Set-only until reset so code cannot unprotect itself
  logic [REGIONS-1:0] ro_reg, ro_next, xo_reg, xo_next;

  // One set-only cell per region
  genvar g;
  generate
    for (g = 0; g < REGIONS; g++) begin : g_prot
      always_comb begin
        ro_next[g] = ro_reg[g] | ro_set_i[g];
        xo_next[g] = xo_reg[g] | xo_set_i[g];
      end
    end
  endgenerate

  // Only reset clears protection; the bits carry no other state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ro_reg <= '0;
      xo_reg <= '0;
    end else begin
      ro_reg <= ro_next;
      xo_reg <= xo_next;
    end
  end

  // Protection state is visible to software as plain outputs
  assign ro_o = ro_reg;
  assign xo_o = xo_reg;

  // ****************************************
  // Access sequencer
  // ****************************************
  state_type            state_reg, state_next;
  logic [WIDX_W-1:0]    widx_reg, widx_next;
  logic [WADDR_W-1:0]   ubase_reg, ubase_next;
  logic                 ack_reg, ack_next;
  logic                 den_reg, den_next;
  logic                 viol_reg, viol_next;
  logic [WORD_W-1:0]    rdata_reg, rdata_next;
  logic                 viol_event;

  // Next-state logic for the sequencer and the array strobes.
  // Array address and data default to the request; only the erase overrides them.
  always_comb begin
    state_next = state_reg;
    widx_next  = widx_reg;
    ubase_next = ubase_reg;
    ack_next   = 1'b0;
    den_next   = den_reg;
    rdata_next = rdata_reg;
    viol_event = 1'b0;
    arr.we     = 1'b0;
    arr.waddr  = addr_i[ADDR_W-1:WORD_LSB];
    arr.wdata  = wdata_i;
    arr.re     = 1'b0;
    arr.raddr  = addr_i[ADDR_W-1:WORD_LSB];
    case (state_reg)
      ST_IDLE: begin
        if (req_i && !ack_reg) begin
          if (refuse) begin
            // Refused requests still answer at once so the requester never hangs
            viol_event = 1'b1;
            den_next   = 1'b1;
            ack_next   = 1'b1;
          end else begin
            den_next = 1'b0;
            case (op_i)
              OP_PROGRAM: begin
                arr.we   = 1'b1;
                ack_next = 1'b1;
              end
              OP_ERASE: begin
                // Base of the 1 KB unit; the word index is counted up below
                ubase_next = {addr_i[ADDR_W-1:UNIT_LSB], {WIDX_W{1'b0}}};
                widx_next  = '0;
                state_next = ST_ERASE;
              end
              default: begin
                // Reads and the unused code both go to the array
                arr.re     = 1'b1;
                state_next = ST_READ;
              end
            endcase
          end
        end
      end
      ST_READ: begin
        // Array data arrive one cycle after the read strobe
        rdata_next = arr.rdata;
        ack_next   = 1'b1;
        state_next = ST_IDLE;
      end
      ST_ERASE: begin
        // One word per cycle: 256 cycles per unit, only this unit's words
        arr.we    = 1'b1;
        arr.waddr = ubase_reg | WADDR_W'(widx_reg);
        arr.wdata = ERASED_WORD;
        widx_next = widx_reg + 1'b1;
        if (widx_reg == WIDX_W'(WORDS_PER_UNIT - 1)) begin
          ack_next   = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Set wins over clear so no violation is lost
    viol_next = viol_event | (viol_reg & ~viol_clr_i);
  end

  // Sequencer registers; flash contents are deliberately not reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      widx_reg  <= '0;
      ubase_reg <= '0;
      ack_reg   <= 1'b0;
      den_reg   <= 1'b0;
      viol_reg  <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      widx_reg  <= widx_next;
      ubase_reg <= ubase_next;
      ack_reg   <= ack_next;
      den_reg   <= den_next;
      viol_reg  <= viol_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // All but busy come straight from flops; busy is a state decode only
  assign ack_o    = ack_reg;
  assign busy_o   = (state_reg != ST_IDLE);
  assign denied_o = den_reg;
  assign viol_o   = viol_reg;
  assign rdata_o  = rdata_reg;
endmodule // flash_erase_protect_ctrl

// >>> dv/flash_prot_chk.sv
// Port checker for the flash erase and protection controller.
// Assumes the hand-over timing; bound to every controller instance.
`timescale 1ns/100ps
module flash_prot_chk
  import flash_prot_pkg::*;
#(
  parameter int unsigned REGIONS = NUM_REGIONS
) (
  input wire logic               clk_sys_i,
  input wire logic               arst_n_i,
  input wire logic               req_i,
  input wire req_op_type         op_i,
  input wire req_src_type        src_i,
  input wire logic [ADDR_W-1:0]  addr_i,
  input wire logic               ack_o,
  input wire logic               busy_o,
  input wire logic               denied_o,
  input wire logic               viol_o,
  input wire logic [REGIONS-1:0] ro_o,
  input wire logic [REGIONS-1:0] xo_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  logic tk, inr, rg_ro, rg_xo;
  // Region bits only looked at for decoded addresses
  assign tk    = req_i && !ack_o && !busy_o;
  assign inr   = addr_i < FLASH_BYTES;
  assign rg_ro = inr && ro_o[addr_i[ADDR_W-1:REGION_LSB]];
  assign rg_xo = inr && xo_o[addr_i[ADDR_W-1:REGION_LSB]];
  sequence s_erase_go; tk && op_i == OP_ERASE && inr && !rg_ro && !rg_xo; endsequence
  sequence s_erase_run; busy_o [*8] ##248 busy_o ##1 (ack_o && !denied_o); endsequence
  property p_range; tk && !inr |=> ack_o && denied_o; endproperty
  property p_prog; tk && op_i == OP_PROGRAM && inr && !rg_ro && !rg_xo |=> ack_o && !denied_o;
  endproperty
  property p_erase; s_erase_go |=> s_erase_run; endproperty
  property p_keep; (($past(ro_o) & ~ro_o) | ($past(xo_o) & ~xo_o)) == '0; endproperty
  property p_ro; tk && op_i inside {OP_PROGRAM, OP_ERASE} && (rg_ro || rg_xo)
    |=> ack_o && denied_o;
  endproperty
  property p_xo; tk && op_i == OP_READ && src_i != SRC_FETCH && rg_xo |=> ack_o && denied_o;
  endproperty
  property p_read; tk && op_i == OP_READ && inr && !rg_xo |=> busy_o ##1 (ack_o && !denied_o);
  endproperty
  // Flag rises with the refusal answer even when a clear is pending
  property p_viol; ack_o && denied_o |-> viol_o; endproperty
  a_range: assert property (p_range) else $error("out of range access served");
  a_prog: assert property (p_prog) else $error("free program not served");
  a_erase: assert property (p_erase) else $error("erase timing wrong");
  a_keep: assert property (p_keep) else $error("protection bit dropped");
  a_ro: assert property (p_ro) else $error("protected write served");
  a_xo: assert property (p_xo) else $error("hidden read served");
  a_read: assert property (p_read) else $error("allowed read refused");
  a_viol: assert property (p_viol) else $error("violation flag missing");
endmodule // flash_prot_chk
bind flash_erase_protect_ctrl flash_prot_chk #(.REGIONS(REGIONS)) i_flash_prot_chk (
  .clk_sys_i (clk_sys_i),
  .arst_n_i  (arst_n_i),
  .req_i     (req_i),
  .op_i      (op_i),
  .src_i     (src_i),
  .addr_i    (addr_i),
  .ack_o     (ack_o),
  .busy_o    (busy_o),
  .denied_o  (denied_o),
  .viol_o    (viol_o),
  .ro_o      (ro_o),
  .xo_o      (xo_o)
);

// >>> dv/flash_requester.sv
// Requester model: fetch, data and debug sides of the flash controller.
// Assumes one request at a time, held until acknowledged.
`timescale 1ns/100ps
module flash_requester
  import flash_prot_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              ack_i,
  input  wire logic [WORD_W-1:0] rdata_i,
  input  wire logic              denied_i,
  output logic                   req_o,
  output req_op_type             op_o,
  output req_src_type            src_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [WORD_W-1:0]      wdata_o
);
  initial begin
    req_o = 1'b0;
    op_o = OP_READ;
    src_o = SRC_FETCH;
    addr_o = '0;
    wdata_o = '0;
  end
  // Released address and write data lines show the inverse so stale values never pass
  task automatic access(input req_op_type op, input req_src_type src,
                        input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w,
                        output logic [WORD_W-1:0] rd, output logic den);
    @(posedge clk_sys_i);
    req_o <= 1'b1;
    op_o <= op;
    src_o <= src;
    addr_o <= a;
    wdata_o <= w;
    do @(negedge clk_sys_i); while (ack_i !== 1'b1);
    rd = rdata_i;
    den = denied_i;
    @(posedge clk_sys_i);
    req_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~w;
  endtask
endmodule // flash_requester

// >>> dv/flash_erase_protect_ctrl_tb.sv
// Testbench for the flash erase and protection controller.
// Assumes the checker is bound by its own file.
`timescale 1ns/100ps
module flash_erase_protect_ctrl_tb;
  import flash_prot_pkg::*;
  logic clk_sys_i, arst_n_i, viol_clr, req, ack, busy, den, denied, viol;
  req_op_type op;
  req_src_type src;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wdata, rdata, rd;
  logic [NUM_REGIONS-1:0] ro_set, xo_set, ro, xo;
  int fails = 0, n_compared = 0, cycles = 0;
  flash_requester i_flash_requester (.clk_sys_i(clk_sys_i), .ack_i(ack), .rdata_i(rdata),
    .denied_i(denied), .req_o(req), .op_o(op), .src_o(src), .addr_o(addr), .wdata_o(wdata));
  flash_erase_protect_ctrl i_flash_erase_protect_ctrl (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .req_i(req), .op_i(op), .src_i(src), .addr_i(addr),
    .wdata_i(wdata), .ro_set_i(ro_set), .xo_set_i(xo_set), .viol_clr_i(viol_clr),
    .ack_o(ack), .busy_o(busy), .rdata_o(rdata), .denied_o(denied), .viol_o(viol),
    .ro_o(ro), .xo_o(xo));
  task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(req_op_type o, req_src_type s, logic [ADDR_W-1:0] a, logic [WORD_W-1:0] w);
    i_flash_requester.access(o, s, a, w, rd, den);
  endtask
  // Erase one unit between two programmed words, then the range ends
  task automatic t_erase_unit();
    acc(OP_PROGRAM, SRC_DATA, 17'h003fc, 32'h1234_5678);
    acc(OP_PROGRAM, SRC_DATA, 17'h00400, 32'h0);
    acc(OP_PROGRAM, SRC_DATA, 17'h00800, 32'h5a5a_5a5a);
    fork
      acc(OP_ERASE, SRC_DEBUG, 17'h00400, 32'h0);
      begin
        repeat (3) @(negedge clk_sys_i);
        check("erase busy", busy, 32'h1);
      end
    join
    check("erase denied", den, 32'h0);
    @(negedge clk_sys_i) check("erase done", busy, 32'h0);
    acc(OP_READ, SRC_DATA, 17'h00400, 32'h0);
    check("unit start", rd, ERASED_WORD);
    acc(OP_READ, SRC_FETCH, 17'h007fc, 32'h0);
    check("unit end", rd, ERASED_WORD);
    acc(OP_READ, SRC_DATA, 17'h003fc, 32'h0);
    check("neighbour", rd, 32'h1234_5678);
    acc(OP_READ, SRC_DATA, 17'h00800, 32'h0);
    check("next unit", rd, 32'h5a5a_5a5a);
    acc(OP_PROGRAM, SRC_DATA, 17'h17ffc, 32'ha5a5_0f0f);
    acc(OP_READ, SRC_DEBUG, 17'h17ffc, 32'h0);
    check("last word", rd, 32'ha5a5_0f0f);
    acc(OP_READ, SRC_DATA, 17'h18000, 32'h0);
    check("beyond end", den, 32'h1);
    check("violation", viol, 32'h1);
    @(posedge clk_sys_i) viol_clr <= 1'b1;
    @(posedge clk_sys_i) viol_clr <= 1'b0;
    @(negedge clk_sys_i) check("cleared", viol, 32'h0);
  endtask
  // Read-only region 2 and execute-only region 3, region 4 left free
  task automatic t_protect();
    acc(OP_PROGRAM, SRC_DATA, 17'h01800, 32'h0bad_c0de);
    @(posedge clk_sys_i) ro_set <= 48'h4;
    xo_set <= 48'h8;
    @(posedge clk_sys_i) ro_set <= '0;
    xo_set <= '0;
    @(negedge clk_sys_i) check("ro bits", {ro[15:0], xo[15:0]}, 32'h0004_0008);
    // Clear held across a refusal: the set must win at the taking edge
    @(posedge clk_sys_i) viol_clr <= 1'b1;
    acc(OP_PROGRAM, SRC_DATA, 17'h01000, 32'h0);
    viol_clr <= 1'b0;
    check("ro program", den, 32'h1);
    @(negedge clk_sys_i) check("clear held", viol, 32'h0);
    acc(OP_READ, SRC_DEBUG, 17'h013fc, 32'h0);
    check("ro read", den, 32'h0);
    for (int i = 0; i < 2; i++) begin
      acc(req_op_type'(i + 1), SRC_FETCH, 17'h01800, 32'h0);
      check("xo write", den, 32'h1);
      acc(OP_READ, req_src_type'(i + 1), 17'h01800, 32'h0);
      check("xo read", den, 32'h1);
    end
    acc(OP_READ, SRC_FETCH, 17'h01800, 32'h0);
    check("xo fetch", rd, 32'h0bad_c0de);
    acc(OP_PROGRAM, SRC_DATA, 17'h02000, 32'h0);
    check("free region", den, 32'h0);
    check("violation", viol, 32'h1);
  endtask
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard: the full run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    arst_n_i = 1'b0;
    viol_clr = 1'b0;
    ro_set = '0;
    xo_set = '0;
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_erase_unit();
    t_protect();
    print_verdict();
  end
endmodule // flash_erase_protect_ctrl_tb
